// ==== verilog/lin_core_regs.vh ====
`ifndef LIN_CORE_REGS_VH
`define LIN_CORE_REGS_VH
// indirect core register indices
`define LC_IDX_DATA_LAST   8'h07
`define LC_IDX_CMD         8'h08
`define LC_IDX_STATE       8'h09
`define LC_IDX_FAULT       8'h0A
`define LC_IDX_LENSUM      8'h0B
`define LC_IDX_SELECTOR    8'h0E
// direct port addresses
`define LC_PORT_INDEX      8'h92
`define LC_PORT_VALUE      8'h93
// frame_command bits
`define LC_CMD_HALT        7
`define LC_CMD_DORMANT     6
`define LC_CMD_DIR         5
`define LC_CMD_ACK         4
`define LC_CMD_IRQCLR      3
`define LC_CMD_FLTCLR      2
`define LC_CMD_ROUSE       1
`define LC_CMD_GO          0
// bus_state bits
`define LC_ST_BUSY         7
`define LC_ST_IDLE         6
`define LC_ST_CUT          5
`define LC_ST_HDR          4
`define LC_ST_IRQ          3
`define LC_ST_FAULT        2
`define LC_ST_ROUSE        1
`define LC_ST_DONE         0
// fault_detail bits
`define LC_FD_RATE         4
`define LC_FD_PARITY       3
`define LC_FD_NORESP       2
`define LC_FD_SUM          1
`define LC_FD_ECHO         0
// length_and_sum_select fields
`define LC_LS_ENH          7
`define LC_LS_AUTO         4'hF
`define LC_RESET_BYTE      8'h00
// idle timeout: four seconds at 25 MHz
`define LC_IDLE_SECONDS    4
`define LC_CLK_HZ          25000000
`define LC_IDLE_CYCLES     (`LC_IDLE_SECONDS * `LC_CLK_HZ)
`endif

// ==== verilog/lin_byte_fifo.v ====
`timescale 1ns/10ps
`default_nettype none
module lin_byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // clock and reset
   input  wire             ref_clk,
   input  wire             rst_n,
   // fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // drain side
   output wire             outValid,
   input  wire             outReady,
   output reg  [WIDTH-1:0] outData,
   // flush
   input  wire             flush
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wrPtr_ff;
   reg [AW:0]      rdPtr_ff;
   reg             outValid_ff;
   wire            empty;
   wire            full;
   wire            doWrite;
   wire            doRead;

   assign empty    = (wrPtr_ff == rdPtr_ff);
   assign full     = (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]) &&
                     (wrPtr_ff[AW] != rdPtr_ff[AW]);
   assign inReady  = ~full;
   assign doWrite  = inValid & ~full;
   // output register refills when empty or being taken
   assign doRead   = ~empty & (~outValid_ff | outReady);
   assign outValid = outValid_ff;

   always @(posedge ref_clk) begin
      if (doWrite)
         mem[wrPtr_ff[AW-1:0]] <= inData;
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_ff    <= {(AW+1){1'b0}};
         rdPtr_ff    <= {(AW+1){1'b0}};
         outValid_ff <= 1'b0;
         outData     <= {WIDTH{1'b0}};
      end else if (flush) begin
         wrPtr_ff    <= {(AW+1){1'b0}};
         rdPtr_ff    <= {(AW+1){1'b0}};
         outValid_ff <= 1'b0;
      end else begin
         if (doWrite)
            wrPtr_ff <= wrPtr_ff + 1'b1;
         if (doRead) begin
            outData     <= mem[rdPtr_ff[AW-1:0]];
            rdPtr_ff    <= rdPtr_ff + 1'b1;
            outValid_ff <= 1'b1;
         end else if (outReady) begin
            outValid_ff <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/lin_core_register_interface.v ====
// Summary of operation
// R1: eight read/write frame data bytes at indices 0x00 to 0x07.
// R2: halt request in slave mode ignores bus until next break; reads zero.
// R3: software sets dormant notice on sleep, clears it on wake-up.
// R4: direction bit zero means receive frame, one means transmit frame.
// R5: slave response acknowledge is written by software, cleared by hardware.
// R6: fault clear wipes fault flag and all fault details; reads zero.
// R7: rouse request sends wakeup on bus, then clears itself; the code clears it but sends no wakeup while the fault flag is set.
// R8: master go starts a frame; cleared on completion or error; the code ignores go while the fault flag is set.
// R9: busy flag shows bus activity.
// R10: slave sets idle expiry after four quiet seconds unless dormant.
// R11: cut-short set by break during frame or halt; cleared by clean break.
// R12: slave sets header matched once an identifier is received.
// R13: pending interrupt held until irq clear written; clear reads zero.
// R14: fault flag set on any error, held until fault clear.
// R15: rouse flag while sending wakeup or after one is received.
// R16: complete flag cleared at frame start, set at completion.
// R17: slave sets rate fault on bad synchronisation field edges.
// R18: slave sets parity fault on bad identifier parity.
// R19: no-response fault on missing response, overlength, or no acknowledge.
// R20: checksum fault when received checksum mismatches computed one.
// R21: echo fault when read-back bus bit differs from driven bit.
// R22: enhanced sum adds protected identifier; classic covers data only; the code adds selector bits 5:0 only, without the parity bits.
// R23: length codes 0 to 8 direct, 9 to 14 reserved, 15 automatic.
// R24: automatic length from identifier bits five and four: 2, 2, 4, 8.
// R25: any error raises interrupt and stops the current frame.
// R26: index port selects core register; value port reads and writes it.
// R27: length code six means six data bytes.
`timescale 1ns/10ps
`default_nettype none
`include "lin_core_regs.vh"
module lin_core_register_interface #(
   parameter [31:0] IDLE_CYCLES = `LC_IDLE_CYCLES,
   parameter        FIFO_DEPTH  = 16
) (
   // clock and reset
   input  wire       ref_clk,
   input  wire       rst_n,
   // direct register port
   input  wire [7:0] portAddr,
   input  wire       portWr,
   input  wire       portRd,
   input  wire [7:0] portWdata,
   output reg  [7:0] portRdata,
   // mode
   input  wire       masterMode,
   // frame engine events (same clock)
   input  wire       evBreak,
   input  wire       evHeader,
   input  wire       evFrameEnd,
   input  wire       evWakeRx,
   input  wire       evWakeTxDone,
   input  wire       evSyncBad,
   input  wire       evParityBad,
   input  wire       evNoResp,
   input  wire       evFirstByteEnd,
   input  wire       evRxByte,
   input  wire [7:0] rxByte,
   input  wire [7:0] rxSum,
   input  wire       txBit,
   input  wire       txActive,
   // bus pin
   input  wire       busIn,
   // frame engine controls
   output reg        frameStart,
   output reg        wakeSend,
   output reg        frameHalted,
   output reg        frameDir,
   output reg  [3:0] frameLen,
   output reg  [7:0] checksum,
   output reg        irqPending
);
   ///////////////////////////////////////////////////////////////////////
   function [3:0] len_decode;
      input [3:0] code;
      input [1:0] idHi;
      begin
         // R23 length decode
         if (code == `LC_LS_AUTO) begin
            // R24 identifier length
            case (idHi)
               2'h2:    len_decode = 4'h4;
               2'h3:    len_decode = 4'h8;
               default: len_decode = 4'h2;
            endcase
         // R27 binary length
         end else if (code <= 4'h8) begin
            len_decode = code;
         end else begin
            len_decode = 4'h0;
         end
      end
   endfunction

   function [7:0] sum_add;
      input [7:0] acc;
      input [7:0] b;
      reg   [8:0] s;
      begin
         s = {1'b0, acc} + {1'b0, b};
         sum_add = s[7:0] + {7'h00, s[8]};
      end
   endfunction
   ///////////////////////////////////////////////////////////////////////
   reg  [7:0]  index_ff;
   reg  [7:0]  data_ff [0:7];
   reg  [7:0]  selector_ff;
   reg  [7:0]  cmd_ff;
   reg  [7:0]  state_ff;
   reg  [4:0]  fault_ff;
   reg  [7:0]  lenSum_ff;
   reg  [7:0]  sumAcc_ff;
   reg  [31:0] idleCnt_ff;
   reg         bus1_ff;
   reg         bus2_ff;
   reg         busPrev_ff;
   reg  [1:0]  txBit_ff;
   reg  [1:0]  txAct_ff;
   reg         inFrame_ff;
   reg         ackSeen_ff;
   reg  [3:0]  fill_ff;
   wire        valWr;
   wire [7:0]  wd;
   wire        anyErr;
   wire        echoBad;
   wire        fifoTake;
   wire        fifoValid;
   wire [7:0]  fifoData;
   wire        slave;
   wire [7:0]  idSum;
   integer     i;

   assign valWr   = portWr && (portAddr == `LC_PORT_VALUE);
   assign wd      = portWdata;
   assign slave   = ~masterMode;
   // R21 echo compare
   assign echoBad = txAct_ff[1] && (bus2_ff != txBit_ff[1]);
   assign anyErr  = evSyncBad | evParityBad | evNoResp | echoBad |
                    (evFrameEnd && ~frameDir && (rxSum != checksum)) |
                    (evFirstByteEnd && slave && ~ackSeen_ff);
   assign idSum   = sum_add(8'h00, selector_ff);
   assign fifoTake = fifoValid && (fill_ff != 4'h8) &&
                     ~(valWr && index_ff <= `LC_IDX_DATA_LAST);

   lin_byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (4)
   ) u_rx_fifo (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .inValid  (evRxByte & ~frameHalted),
      .inReady  (),
      .inData   (rxByte),
      .outValid (fifoValid),
      .outReady (fifoTake),
      .outData  (fifoData),
      .flush    (evBreak)
   );
   ///////////////////////////////////////////////////////////////////////
   // bus pin synchroniser and activity
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus1_ff    <= 1'b1;
         bus2_ff    <= 1'b1;
         busPrev_ff <= 1'b1;
         txBit_ff   <= 2'b00;
         txAct_ff   <= 2'b00;
      end else begin
         bus1_ff    <= busIn;
         bus2_ff    <= bus1_ff;
         busPrev_ff <= bus2_ff;
         txBit_ff   <= {txBit_ff[0], txBit};
         txAct_ff   <= {txAct_ff[0], txActive};
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // register port reads
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         portRdata   <= `LC_RESET_BYTE;
      end else begin
         // R26 indirect access
         if (portRd && portAddr == `LC_PORT_INDEX)
            portRdata <= index_ff;
         else if (portRd && portAddr == `LC_PORT_VALUE) begin
            if (index_ff <= `LC_IDX_DATA_LAST)
               portRdata <= data_ff[index_ff[2:0]];
            // R2 write-only bits read zero
            else if (index_ff == `LC_IDX_CMD)
               portRdata <= {1'b0, cmd_ff[6:4], 2'b00, cmd_ff[1:0]};
            else if (index_ff == `LC_IDX_STATE)
               portRdata <= state_ff;
            else if (index_ff == `LC_IDX_FAULT)
               portRdata <= {3'b000, fault_ff};
            else if (index_ff == `LC_IDX_LENSUM)
               portRdata <= {lenSum_ff[7], 3'b000, lenSum_ff[3:0]};
            else if (index_ff == `LC_IDX_SELECTOR)
               portRdata <= {2'b00, selector_ff[5:0]};
            else
               portRdata <= `LC_RESET_BYTE;
         end
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // writes, command handling and status
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         index_ff    <= `LC_RESET_BYTE;
         selector_ff <= `LC_RESET_BYTE;
         cmd_ff      <= `LC_RESET_BYTE;
         state_ff    <= `LC_RESET_BYTE;
         fault_ff    <= 5'h00;
         lenSum_ff   <= `LC_RESET_BYTE;
         sumAcc_ff   <= `LC_RESET_BYTE;
         idleCnt_ff  <= 32'h00000000;
         inFrame_ff  <= 1'b0;
         ackSeen_ff  <= 1'b0;
         fill_ff     <= 4'h0;
         frameStart  <= 1'b0;
         wakeSend    <= 1'b0;
         frameHalted <= 1'b0;
         for (i = 0; i < 8; i = i + 1)
            data_ff[i] <= `LC_RESET_BYTE;
      end else begin
         frameStart <= 1'b0;
         wakeSend   <= 1'b0;
         if (portWr && portAddr == `LC_PORT_INDEX)
            index_ff <= wd;
         // R1 data bytes
         if (valWr && index_ff <= `LC_IDX_DATA_LAST)
            data_ff[index_ff[2:0]] <= wd;
         else if (fifoTake) begin
            data_ff[fill_ff[2:0]] <= fifoData;
            fill_ff <= fill_ff + 4'h1;
            sumAcc_ff <= sum_add(sumAcc_ff, fifoData);
         end
         if (valWr && index_ff == `LC_IDX_LENSUM)
            lenSum_ff <= wd;
         if (valWr && index_ff == `LC_IDX_SELECTOR)
            selector_ff <= {2'b00, wd[5:0]};
         // R8 go cleared on end or error
         if (cmd_ff[`LC_CMD_GO] && (evFrameEnd || anyErr))
            cmd_ff[`LC_CMD_GO] <= 1'b0;
         // R5 ack self-clears
         if (cmd_ff[`LC_CMD_ACK])
            cmd_ff[`LC_CMD_ACK] <= 1'b0;
         // R7 rouse self-clears
         if (cmd_ff[`LC_CMD_ROUSE]) begin
            cmd_ff[`LC_CMD_ROUSE] <= 1'b0;
            wakeSend <= ~state_ff[`LC_ST_FAULT];
         end
         if (valWr && index_ff == `LC_IDX_CMD) begin
            // R3 dormant notice and R4 direction
            cmd_ff[`LC_CMD_DORMANT] <= wd[`LC_CMD_DORMANT];
            cmd_ff[`LC_CMD_DIR]     <= wd[`LC_CMD_DIR];
            cmd_ff[`LC_CMD_ACK]     <= wd[`LC_CMD_ACK] & slave;
            cmd_ff[`LC_CMD_ROUSE]   <= wd[`LC_CMD_ROUSE];
            if (wd[`LC_CMD_ACK] && slave)
               ackSeen_ff <= 1'b1;
            // R8 master start
            if (wd[`LC_CMD_GO] && masterMode &&
                ~state_ff[`LC_ST_FAULT]) begin
               cmd_ff[`LC_CMD_GO] <= 1'b1;
               frameStart <= 1'b1;
            end
            // R2 halt until break
            if (wd[`LC_CMD_HALT] && slave) begin
               frameHalted <= 1'b1;
               inFrame_ff  <= 1'b0;
               ackSeen_ff  <= 1'b1;
            end
         end
         // R9 bus activity
         state_ff[`LC_ST_BUSY] <= inFrame_ff | txActive |
                                  (bus2_ff != busPrev_ff);
         // R10 idle timeout
         if (bus2_ff != busPrev_ff || cmd_ff[`LC_CMD_DORMANT] || ~slave)
            idleCnt_ff <= 32'h00000000;
         else if (idleCnt_ff != IDLE_CYCLES)
            idleCnt_ff <= idleCnt_ff + 32'h00000001;
         if (slave && ~cmd_ff[`LC_CMD_DORMANT] &&
             idleCnt_ff == IDLE_CYCLES - 32'h00000001)
            state_ff[`LC_ST_IDLE] <= 1'b1;
         else if (bus2_ff != busPrev_ff)
            state_ff[`LC_ST_IDLE] <= 1'b0;
         // R11 cut short
         if (evBreak && slave) begin
            state_ff[`LC_ST_CUT] <= inFrame_ff;
            frameHalted <= 1'b0;
            ackSeen_ff  <= 1'b0;
         end
         if (valWr && index_ff == `LC_IDX_CMD && wd[`LC_CMD_HALT] && slave)
            state_ff[`LC_ST_CUT] <= 1'b1;
         // R16 completion flag
         if (frameStart || evHeader) begin
            state_ff[`LC_ST_DONE] <= 1'b0;
            inFrame_ff <= 1'b1;
            fill_ff    <= 4'h0;
            sumAcc_ff  <= lenSum_ff[`LC_LS_ENH] ? idSum : 8'h00;
         end
         if (evFrameEnd || evWakeRx || evWakeTxDone) begin
            state_ff[`LC_ST_DONE] <= 1'b1;
            inFrame_ff <= 1'b0;
         end
         // R12 header matched
         if (evHeader && slave && ~frameHalted)
            state_ff[`LC_ST_HDR] <= 1'b1;
         else if (evBreak)
            state_ff[`LC_ST_HDR] <= 1'b0;
         // R15 rouse flag
         if (wakeSend || evWakeRx)
            state_ff[`LC_ST_ROUSE] <= 1'b1;
         else if (~cmd_ff[`LC_CMD_DORMANT] && evBreak)
            state_ff[`LC_ST_ROUSE] <= 1'b0;
         // R25 error stops frame
         if (anyErr)
            inFrame_ff <= 1'b0;
         // R6 fault clear
         if (valWr && index_ff == `LC_IDX_CMD && wd[`LC_CMD_FLTCLR]) begin
            state_ff[`LC_ST_FAULT] <= 1'b0;
            fault_ff <= 5'h00;
         end
         // R17 R18 R19 R20 R21 detail set wins over clear
         if (evSyncBad && slave)
            fault_ff[`LC_FD_RATE] <= 1'b1;
         if (evParityBad && slave)
            fault_ff[`LC_FD_PARITY] <= 1'b1;
         if (evNoResp || (evFirstByteEnd && slave && ~ackSeen_ff))
            fault_ff[`LC_FD_NORESP] <= 1'b1;
         if (evFrameEnd && ~frameDir && rxSum != checksum)
            fault_ff[`LC_FD_SUM] <= 1'b1;
         if (echoBad)
            fault_ff[`LC_FD_ECHO] <= 1'b1;
         // R14 fault flag
         if (anyErr)
            state_ff[`LC_ST_FAULT] <= 1'b1;
         // R13 pending interrupt
         if (valWr && index_ff == `LC_IDX_CMD && wd[`LC_CMD_IRQCLR])
            state_ff[`LC_ST_IRQ] <= 1'b0;
         if (anyErr || evFrameEnd || evWakeRx || evHeader ||
             (evWakeTxDone && masterMode) ||
             (slave && ~cmd_ff[`LC_CMD_DORMANT] &&
              idleCnt_ff == IDLE_CYCLES - 32'h00000001))
            state_ff[`LC_ST_IRQ] <= 1'b1;
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // frame engine outputs
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frameDir   <= 1'b0;
         frameLen   <= 4'h0;
         checksum   <= `LC_RESET_BYTE;
         irqPending <= 1'b0;
      end else begin
         frameDir   <= cmd_ff[`LC_CMD_DIR];
         frameLen   <= len_decode(lenSum_ff[3:0], selector_ff[5:4]);
         // R22 classic or enhanced sum
         checksum   <= ~sumAcc_ff;
         irqPending <= state_ff[`LC_ST_IRQ];
      end
   end
endmodule
`default_nettype wire

// ==== verif/lin_core_register_interface_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lin_core_regs.vh"
module lin_core_sva (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // register port
   input wire logic [7:0] portAddr,
   input wire logic       portWr,
   input wire logic       portRd,
   input wire logic [7:0] portWdata,
   input wire logic [7:0] portRdata,
   // mode and engine side
   input wire logic       masterMode,
   input wire logic       frameStart,
   input wire logic       wakeSend,
   input wire logic       frameHalted,
   input wire logic       frameDir,
   input wire logic       irqPending
);
   logic [7:0] idx_ff;
   logic       cmdWr;
   logic       valRd;
   ////////////////////////////////////////////////////////////////////////////
   // shadow of the index port so value accesses can be decoded
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) idx_ff <= 8'h00;
      else if (portWr && portAddr == `LC_PORT_INDEX) idx_ff <= portWdata;
   end
   assign cmdWr = portWr && portAddr == `LC_PORT_VALUE &&
                  idx_ff == `LC_IDX_CMD;
   assign valRd = portRd && portAddr == `LC_PORT_VALUE;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   chk_go_cause: assert property (
      frameStart |-> $past(cmdWr && portWdata[0] && masterMode))
      else $error("frame start without go write");
   chk_go_pulse: assert property (
      frameStart |=> !frameStart) else $error("frame start too long");
   chk_wake_cause: assert property (
      wakeSend |-> $past(cmdWr && portWdata[1], 2))
      else $error("wakeup without rouse write");
   chk_wake_pulse: assert property (
      wakeSend |=> !wakeSend) else $error("wakeup pulse too long");
   chk_read_stands: assert property (
      !$past(portRd) |-> $stable(portRdata))
      else $error("read data moved without read");
   chk_read_unmapped: assert property (
      valRd && idx_ff > 8'h0E |=> portRdata == 8'h00)
      else $error("unmapped index read nonzero");
   chk_cmd_zero: assert property (
      valRd && idx_ff == `LC_IDX_CMD |=> (portRdata & 8'h8C) == 8'h00)
      else $error("write-only command bits read back");
   chk_halt_slave: assert property (
      $rose(frameHalted) |-> !$past(masterMode))
      else $error("halt taken in master mode");
   chk_dir_cause: assert property (
      $changed(frameDir) |-> $past(cmdWr, 2))
      else $error("direction moved without write");
   chk_irq_hold: assert property (
      irqPending && !(cmdWr && portWdata[3]) &&
      !$past(cmdWr && portWdata[3]) |=> irqPending)
      else $error("pending interrupt dropped");
endmodule
`default_nettype wire

// ==== verif/lin_engine_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lin_engine_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // requests from the core
   input wire logic frameStart,
   input wire logic wakeSend,
   // bench control
   input wire logic corrupt,
   // answers to the core
   output logic     evFrameEnd,
   output logic     evWakeTxDone,
   output logic     txActive,
   output logic     txBit,
   output logic     busIn
);
   int frameCnt;
   int wakeCnt;
   ////////////////////////////////////////////////////////////////////////////
   // end frame and wakeup after a fixed span
   always @(negedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frameCnt     <= 0;
         wakeCnt      <= 0;
         evFrameEnd   <= 1'b0;
         evWakeTxDone <= 1'b0;
      end else begin
         evFrameEnd   <= frameCnt == 1;
         evWakeTxDone <= wakeCnt == 1;
         if (frameStart) frameCnt <= 20;
         else if (frameCnt > 0) frameCnt <= frameCnt - 1;
         if (wakeSend) wakeCnt <= 10;
         else if (wakeCnt > 0) wakeCnt <= wakeCnt - 1;
      end
   end
   assign txActive = frameCnt > 0 || wakeCnt > 0;
   assign txBit    = wakeCnt > 0 ? 1'b0 : frameCnt[1];
   // read-back corrupted on request, pull-up when idle
   assign busIn    = txActive ? txBit ^ corrupt : 1'b1;
endmodule
`default_nettype wire

// ==== verif/lin_core_register_interface_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lin_core_regs.vh"
module lin_core_register_interface_tb;
   logic       ref_clk, rst_n, portWr, portRd, masterMode, corrupt;
   logic [7:0] portAddr, portWdata, portRdata, ev, rxByte, rxSum;
   logic       evFrameEnd, evWakeTxDone, txActive, txBit, busIn;
   logic       frameStart, wakeSend, frameHalted, frameDir, irqPending;
   logic [3:0] frameLen;
   logic [7:0] checksum;
   int         bad_count, tests_run, starts, wakes, i;
   logic [23:0] rows [12] = '{24'h00A5A5, 24'h015A5A, 24'h020101,
      24'h038080, 24'h04FFFF, 24'h050000, 24'h063C3C, 24'h07C3C3,
      24'h0AFF00, 24'h0BF585, 24'h0EFF3F, 24'h0F5A00};
   lin_core_register_interface #(.IDLE_CYCLES(50)) i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .portAddr(portAddr),
      .portWr(portWr), .portRd(portRd), .portWdata(portWdata),
      .portRdata(portRdata), .masterMode(masterMode), .evBreak(ev[0]),
      .evHeader(ev[1]), .evFrameEnd(evFrameEnd), .evWakeRx(ev[2]),
      .evWakeTxDone(evWakeTxDone), .evSyncBad(ev[3]),
      .evParityBad(ev[4]), .evNoResp(ev[5]), .evFirstByteEnd(ev[6]),
      .evRxByte(ev[7]), .rxByte(rxByte), .rxSum(rxSum), .txBit(txBit),
      .txActive(txActive), .busIn(busIn), .frameStart(frameStart),
      .wakeSend(wakeSend), .frameHalted(frameHalted),
      .frameDir(frameDir), .frameLen(frameLen), .checksum(checksum),
      .irqPending(irqPending));
   lin_engine_model i_far (.ref_clk(ref_clk), .rst_n(rst_n),
      .frameStart(frameStart), .wakeSend(wakeSend), .corrupt(corrupt),
      .evFrameEnd(evFrameEnd), .evWakeTxDone(evWakeTxDone),
      .txActive(txActive), .txBit(txBit), .busIn(busIn));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (frameStart === 1'b1) starts++;
      if (wakeSend === 1'b1) wakes++;
   end
   task automatic print_verdict;
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      portAddr  = a;
      portWdata = d;
      portWr    = 1'b1;
      @(negedge ref_clk);
      portWr    = 1'b0;
   endtask
   task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
      put(`LC_PORT_INDEX, idx);
      put(`LC_PORT_VALUE, d);
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] m,
                        input logic [7:0] exp, input string what);
      put(`LC_PORT_INDEX, idx);
      @(negedge ref_clk);
      portAddr = `LC_PORT_VALUE;
      portRd   = 1'b1;
      @(negedge ref_clk);
      portRd   = 1'b0;
      chk(what, exp, portRdata & m);
   endtask
   task automatic pulse(input int n);
      @(negedge ref_clk);
      ev[n] = 1'b1;
      @(negedge ref_clk);
      ev[n] = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {portAddr, portWdata, ev, rxByte, rxSum} = 40'h0;
      {portWr, portRd, corrupt, rst_n} = 4'h0;
      masterMode = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         wrReg(rows[i][23:16], rows[i][15:8]);
         rdChk(rows[i][23:16], 8'hFF, rows[i][7:0], "register row");
      end
      for (i = 0; i < 16; i++) begin
         wrReg(`LC_IDX_LENSUM, 8'(i));
         wrReg(`LC_IDX_SELECTOR, 8'h20);
         chk("length", 8'(i < 9 ? i : (i == 15 ? 4 : 0)), {4'h0, frameLen});
      end
      for (i = 0; i < 4; i++) begin
         wrReg(`LC_IDX_SELECTOR, 8'(i << 4));
         repeat (2) @(negedge ref_clk);
         chk("auto length", 8'(i == 3 ? 8 : (i == 2 ? 4 : 2)), {4'h0, frameLen});
      end
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      for (i = 0; i < 12; i++) rdChk(8'(i), 8'hFF, 8'h00, "reset value");
      wrReg(`LC_IDX_LENSUM, 8'h02);
      wrReg(`LC_IDX_CMD, 8'h21);
      rdChk(`LC_IDX_STATE, 8'h81, 8'h80, "busy not done");
      chk("direction", 8'h01, {7'h0, frameDir});
      rdChk(`LC_IDX_CMD, 8'h01, 8'h01, "go held");
      chk("start count", 8'h01, 8'(starts));
      repeat (30) @(negedge ref_clk);
      rdChk(`LC_IDX_STATE, 8'h81, 8'h01, "idle done");
      rdChk(`LC_IDX_CMD, 8'h01, 8'h00, "go cleared");
      corrupt = 1'b1;
      wrReg(`LC_IDX_CMD, 8'h21);
      repeat (30) @(negedge ref_clk);
      corrupt = 1'b0;
      rdChk(`LC_IDX_FAULT, 8'hFF, 8'h01, "echo fault");
      rdChk(`LC_IDX_CMD, 8'h01, 8'h00, "go cleared by error");
      wrReg(`LC_IDX_CMD, 8'h0C);
      wrReg(`LC_IDX_CMD, 8'h02);
      rdChk(`LC_IDX_STATE, 8'h02, 8'h02, "rouse sending");
      chk("wake count", 8'h01, 8'(wakes));
      repeat (12) @(negedge ref_clk);
      rdChk(`LC_IDX_CMD, 8'h02, 8'h00, "rouse cleared");
      masterMode = 1'b0;
      wrReg(`LC_IDX_CMD, 8'h49);
      rdChk(`LC_IDX_CMD, 8'h41, 8'h40, "slave go refused");
      for (i = 0; i < 3; i++) begin
         pulse(3 + i);
         rdChk(`LC_IDX_FAULT, 8'hFF, 8'h10 >> i, "fault bit");
         rdChk(`LC_IDX_STATE, 8'h0C, 8'h0C, "fault irq");
         chk("irq pin", 8'h01, {7'h0, irqPending});
         masterMode = i == 0;
         wrReg(`LC_IDX_CMD, 8'h41);
         masterMode = 1'b0;
         wrReg(`LC_IDX_CMD, 8'h44);
         rdChk(`LC_IDX_FAULT, 8'hFF, 8'h00, "fault cleared");
         chk("irq kept", 8'h01, {7'h0, irqPending});
         wrReg(`LC_IDX_CMD, 8'h48);
         @(negedge ref_clk);
         chk("irq cleared", 8'h00, {7'h0, irqPending});
      end
      chk("go with fault", 8'h02, 8'(starts));
      pulse(0);
      pulse(1);
      for (i = 0; i < 3; i++) begin
         rxByte = 8'h30 + 8'(i);
         pulse(7);
      end
      repeat (4) @(negedge ref_clk);
      for (i = 0; i < 3; i++) rdChk(8'(i), 8'hFF, 8'h30 + 8'(i), "rx byte");
      rdChk(`LC_IDX_STATE, 8'h10, 8'h10, "header matched");
      chk("checksum", 8'h6C, checksum);
      wrReg(`LC_IDX_CMD, 8'hC0);
      chk("halted", 8'h01, {7'h0, frameHalted});
      rdChk(`LC_IDX_STATE, 8'h60, 8'h20, "cut short");
      pulse(0);
      chk("halt released", 8'h00, {7'h0, frameHalted});
      rdChk(`LC_IDX_STATE, 8'h20, 8'h00, "clean break");
      wrReg(`LC_IDX_CMD, 8'h08);
      repeat (60) @(negedge ref_clk);
      rdChk(`LC_IDX_STATE, 8'h40, 8'h40, "idle expired");
      print_verdict();
   end
   initial begin
      #(40 * 20000);
      bad_count++;
      print_verdict();
   end
endmodule
bind lin_core_register_interface lin_core_sva i_sva (.ref_clk(ref_clk),
   .rst_n(rst_n), .portAddr(portAddr), .portWr(portWr), .portRd(portRd),
   .portWdata(portWdata), .portRdata(portRdata), .masterMode(masterMode),
   .frameStart(frameStart), .wakeSend(wakeSend), .frameDir(frameDir),
   .frameHalted(frameHalted), .irqPending(irqPending));
`default_nettype wire
